// >>> rtl/pcpc_cfg.svh
`ifndef PCPC_CFG_SVH
`define PCPC_CFG_SVH
`define PCPC_ADDR_DIV_A     8'h01
`define PCPC_ADDR_DIV_B     8'h02
`define PCPC_ADDR_HS_POL    8'h12
`define PCPC_ADDR_COAST_POL 8'h18
`define PCPC_ADDR_PHASE     8'h03
`define PCPC_ADDR_BAND      8'h04
`define PCPC_HS_POL_LSB     4
`define PCPC_COAST_POL_LSB  5
`define PCPC_RST_DIV        12'h640
`define PCPC_RST_HS_POL     8'h10
`define PCPC_RST_COAST_POL  8'h00
`define PCPC_RST_PHASE      5'h00
`define PCPC_RST_BAND       5'h08
`define PCPC_CNT_SAT        12'hfff
`define PCPC_DIV_MIN        12'h002
`define PCPC_PHASE_STEPS    32
`define PCPC_VCO_PERIOD_MAX 8'hff
`endif

// >>> rtl/pcpc_pkg.sv
`include "pcpc_cfg.svh"
package pcpc_pkg;
  typedef enum logic [1:0] {
    PCPC_BAND_10_21 = 2'b00,
    PCPC_BAND_21_42 = 2'b01,
    PCPC_BAND_42_84 = 2'b10,
    PCPC_BAND_84_95 = 2'b11
  } pcpc_band_e;
  typedef logic [11:0] pcpc_div_t;
  typedef logic [4:0]  pcpc_phase_t;
endpackage

// >>> rtl/pcpc_sync3.sv
module pcpc_sync3 import pcpc_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // pin side
  input  wire logic pin_in,
  // filtered level
  output logic      lvl_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      lvl_out <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // change only once stages two and three agree
      if (s2_ff == s3_ff) begin
        lvl_out <= s3_ff;
      end
    end
  end
endmodule

// >>> rtl/pcpc_top.sv
`include "pcpc_cfg.svh"
module pcpc_top import pcpc_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // configuration port
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  // sync and hold pins
  input  wire logic        hsync_pin,
  input  wire logic        vsync_pin,
  input  wire logic        coast_pin,
  input  wire logic        coast_internal_en,
  // clock source select
  input  wire logic        ext_clk_sel,
  input  wire logic        ext_pixel_tick,
  // loop status and analog controls
  output logic             pixel_tick,
  output logic             sample_tick,
  output logic             pll_locked,
  output logic             hold_active,
  output logic [1:0]       osc_band_setting,
  output logic             osc_band_sel_hi,
  output logic             osc_band_sel_lo,
  output logic [2:0]       pump_current_sel,
  output logic             phase_aligned_hsync_out
);
  logic [7:0]  div_a_ff;
  logic [7:0]  div_b_ff;
  logic [7:0]  hs_pol_reg_ff;
  logic [7:0]  coast_pol_reg_ff;
  logic [4:0]  phase_ff;
  logic [4:0]  band_reg_ff;
  pcpc_div_t   divisor;
  logic        hs_sync;
  logic        vs_sync;
  logic        co_sync;
  logic        hs_act;
  logic        hs_prev_ff;
  logic        hs_edge;
  logic        hold;
  pcpc_div_t   pix_cnt_ff;
  logic [7:0]  period_ff;
  logic [7:0]  tick_cnt_ff;
  logic        gen_tick;
  logic        px;
  logic [31:0] hs_dly_ff;
  logic [31:0] px_dly_ff;

  // registers; divisor split over two locations, high part first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_a_ff         <= 8'(`PCPC_RST_DIV >> 4);
      div_b_ff         <= {4'(`PCPC_RST_DIV), 4'h0};
      hs_pol_reg_ff    <= `PCPC_RST_HS_POL;
      coast_pol_reg_ff <= `PCPC_RST_COAST_POL;
      phase_ff         <= `PCPC_RST_PHASE;
      band_reg_ff      <= `PCPC_RST_BAND;
    end else if (cfg_we) begin
      case (cfg_addr)
        `PCPC_ADDR_DIV_A:     div_a_ff <= cfg_wdata;
        `PCPC_ADDR_DIV_B:     div_b_ff <= {cfg_wdata[7:4], 4'h0};
        `PCPC_ADDR_HS_POL:    hs_pol_reg_ff <= cfg_wdata;
        `PCPC_ADDR_COAST_POL: coast_pol_reg_ff <= cfg_wdata;
        `PCPC_ADDR_PHASE:     phase_ff <= cfg_wdata[7:3];
        `PCPC_ADDR_BAND:      band_reg_ff <= cfg_wdata[7:3];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (cfg_addr)
      `PCPC_ADDR_DIV_A:     cfg_rdata = div_a_ff;
      `PCPC_ADDR_DIV_B:     cfg_rdata = div_b_ff;
      `PCPC_ADDR_HS_POL:    cfg_rdata = hs_pol_reg_ff;
      `PCPC_ADDR_COAST_POL: cfg_rdata = coast_pol_reg_ff;
      `PCPC_ADDR_PHASE:     cfg_rdata = {phase_ff, 3'h0};
      `PCPC_ADDR_BAND:      cfg_rdata = {band_reg_ff, 3'h0};
      default:              cfg_rdata = 8'h00;
    endcase
  end

  assign divisor = {div_a_ff, div_b_ff[7:4]};
  assign osc_band_setting = band_reg_ff[4:3];
  assign osc_band_sel_hi  = band_reg_ff[4];
  assign osc_band_sel_lo  = band_reg_ff[3];
  assign pump_current_sel = band_reg_ff[2:0];

  pcpc_sync3 u_hs (.clk(clk), .arst_n(arst_n), .pin_in(hsync_pin), .lvl_out(hs_sync));
  pcpc_sync3 u_vs (.clk(clk), .arst_n(arst_n), .pin_in(vsync_pin), .lvl_out(vs_sync));
  pcpc_sync3 u_co (.clk(clk), .arst_n(arst_n), .pin_in(coast_pin), .lvl_out(co_sync));

  // polarity bit of one means active high
  assign hs_act = hs_sync ~^ hs_pol_reg_ff[`PCPC_HS_POL_LSB];
  // internal hold follows the filtered vertical sync level directly
  assign hold = coast_internal_en ? vs_sync
              : (co_sync ~^ coast_pol_reg_ff[`PCPC_COAST_POL_LSB]);
  assign hold_active = hold;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_prev_ff <= 1'b0;
    end else begin
      hs_prev_ff <= hs_act;
    end
  end
  assign hs_edge = hs_act & ~hs_prev_ff;

  // digital stand-in for the oscillator: tick every period_ff+1 clocks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_ff <= 8'h00;
    end else if (tick_cnt_ff >= period_ff) begin
      tick_cnt_ff <= 8'h00;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 8'h01;
    end
  end
  assign gen_tick   = (tick_cnt_ff >= period_ff);
  assign px         = ext_clk_sel ? ext_pixel_tick : gen_tick;
  assign pixel_tick = px;

  // divider count; restarted on every sync edge, also while holding,
  // so a hold released after sync has returned never compares a stale multi-line count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_cnt_ff <= 12'h000;
    end else if (hs_edge) begin
      // a tick on the edge cycle belongs to the new line
      pix_cnt_ff <= px ? 12'h001 : 12'h000;
    end else if (px && pix_cnt_ff != `PCPC_CNT_SAT) begin
      pix_cnt_ff <= pix_cnt_ff + 12'h001;
    end
  end

  // frequency correction; hold freezes correction and lock status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_ff  <= 8'h00;
      pll_locked <= 1'b0;
    end else if (hs_edge && !hold) begin
      // too few pixel ticks: oscillator slow, shorten period
      if (pix_cnt_ff < divisor && period_ff != 8'h00) begin
        period_ff  <= period_ff - 8'h01;
        pll_locked <= 1'b0;
      end else if (pix_cnt_ff > divisor && period_ff != `PCPC_VCO_PERIOD_MAX) begin
        period_ff  <= period_ff + 8'h01;
        pll_locked <= 1'b0;
      end else begin
        // pinned at a period limit is not lock
        pll_locked <= (pix_cnt_ff == divisor);
      end
    end
  end

  // phase shift: delay line of 32 taps, tap 0 is undelayed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_dly_ff <= 32'h0;
      px_dly_ff <= 32'h0;
    end else begin
      hs_dly_ff <= {hs_dly_ff[30:0], hs_act};
      px_dly_ff <= {px_dly_ff[30:0], px};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_aligned_hsync_out <= 1'b0;
      sample_tick             <= 1'b0;
    end else begin
      // same tap for sync and sample clock keeps them aligned
      phase_aligned_hsync_out <= (phase_ff == 5'h00) ? hs_act
                               : hs_dly_ff[phase_ff - 5'h01];
      sample_tick             <= (phase_ff == 5'h00) ? px
                               : px_dly_ff[phase_ff - 5'h01];
    end
  end

  chk_hold_freezes: assert property (@(posedge clk) disable iff (!arst_n)
    hold |=> $stable(period_ff)) else $error("period moved during hold");
  chk_phase_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_ff == 5'h00 && $stable(phase_ff)) |=> sample_tick == $past(px))
    else $error("phase zero not undelayed");
  chk_sync_align: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_ff == 5'h01 && $past(phase_ff) == 5'h01)
      |=> phase_aligned_hsync_out == $past(hs_dly_ff[0]))
    else $error("sync tap wrong");
  chk_pol_high: assert property (@(posedge clk) disable iff (!arst_n)
    hs_pol_reg_ff[`PCPC_HS_POL_LSB] |-> hs_act == hs_sync) else $error("hsync polarity");
  chk_div_write: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_we && cfg_addr == `PCPC_ADDR_DIV_A) |=> divisor[11:4] == $past(cfg_wdata))
    else $error("divisor write lost");
  chk_band_out: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_we && cfg_addr == `PCPC_ADDR_BAND) |=> osc_band_setting == $past(cfg_wdata[7:6]))
    else $error("band not applied");
  chk_pump_out: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_we && cfg_addr == `PCPC_ADDR_BAND) |=> pump_current_sel == $past(cfg_wdata[5:3]))
    else $error("pump not applied");
  chk_int_hold: assert property (@(posedge clk) disable iff (!arst_n)
    coast_internal_en |-> hold == vs_sync) else $error("internal hold wrong");
  chk_lock_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (hs_edge && !hold && pix_cnt_ff != divisor) |=> !pll_locked)
    else $error("lock kept on count mismatch");
  chk_pol_low: assert property (@(posedge clk) disable iff (!arst_n)
    !hs_pol_reg_ff[`PCPC_HS_POL_LSB] |-> hs_act != hs_sync) else $error("hsync low polarity");
  cov_lock:    cover property (@(posedge clk) disable iff (!arst_n) $rose(pll_locked));
  cov_hold:    cover property (@(posedge clk) disable iff (!arst_n) hold && hs_edge);
  cov_ext:     cover property (@(posedge clk) disable iff (!arst_n) ext_clk_sel && sample_tick);
  cov_ph_max:  cover property (@(posedge clk) disable iff (!arst_n) phase_ff == 5'h1f && sample_tick);
endmodule

// >>> tb/pcpc_hs_src.sv
module pcpc_hs_src #(
  parameter int PER = 32
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // control
  input  wire logic run,
  input  wire logic pol,
  // sync line
  output logic      hsync
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_ff <= 8'h00;
    else cnt_ff <= (cnt_ff == 8'(PER - 1)) ? 8'h00 : cnt_ff + 8'h01;
  end
  // stopped source rests at the inactive level, so a missing sync looks real
  assign hsync = (run && cnt_ff < 8'h04) ? pol : !pol;
endmodule

// >>> tb/pcpc_top_tb.sv
module pcpc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, arst_n = 1'b0, cfg_we = 1'b0, hs_run = 1'b0, hs_pol = 1'b1;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic       vsync_pin = 1'b0, coast_pin = 1'b0, coast_internal_en = 1'b0;
  logic       ext_clk_sel = 1'b1, ext_pixel_tick = 1'b0, hsync_pin;
  logic       pixel_tick, sample_tick, pll_locked, hold_active, osc_band_sel_hi;
  logic       osc_band_sel_lo, phase_aligned_hsync_out;
  logic [1:0] osc_band_setting;
  logic [2:0] pump_current_sel;
  logic [4:0] tbl [6] = '{5'b11001, 5'b10000, 5'b00001, 5'b01000, 5'b11111, 5'b11100};
  int         miscompares = 0;
  int         n_checks = 0;
  always #10 clk = ~clk;
  pcpc_hs_src #(.PER(32)) src (.clk(clk), .arst_n(arst_n), .run(hs_run), .pol(hs_pol),
    .hsync(hsync_pin));
  pcpc_top dut (.clk(clk), .arst_n(arst_n), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .hsync_pin(hsync_pin),
    .vsync_pin(vsync_pin), .coast_pin(coast_pin), .coast_internal_en(coast_internal_en),
    .ext_clk_sel(ext_clk_sel), .ext_pixel_tick(ext_pixel_tick), .pixel_tick(pixel_tick),
    .sample_tick(sample_tick), .pll_locked(pll_locked), .hold_active(hold_active),
    .osc_band_setting(osc_band_setting), .osc_band_sel_hi(osc_band_sel_hi),
    .osc_band_sel_lo(osc_band_sel_lo), .pump_current_sel(pump_current_sel),
    .phase_aligned_hsync_out(phase_aligned_hsync_out));
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lim(input int n, input int max);
    if (n >= max) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [11:0] e);
    @(posedge clk);
    cfg_addr <= a;
    @(negedge clk);
    chk(cfg_rdata, e);
  endtask
  task automatic t_regs;
    rd(8'h01, 12'h064);
    rd(8'h02, 12'h000);
    rd(8'h04, 12'h040);
    rd(8'h12, 12'h010);
    chk({osc_band_setting, pump_current_sel}, 12'h008);
    wr(8'h01, 8'hff);
    wr(8'h02, 8'hf5);
    rd(8'h01, 12'h0ff);
    rd(8'h02, 12'h0f0);
    wr(8'h7f, 8'ha5);
    rd(8'h7f, 12'h000);
  endtask
  task automatic t_band;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(8'h04, {c[1:0], c, 3'b000});
      @(negedge clk);
      chk({osc_band_sel_hi, osc_band_sel_lo, osc_band_setting}, {c[1:0], c[1:0]});
      chk(pump_current_sel, c);
    end
  endtask
  task automatic t_phase(input logic [4:0] p);
    int n;
    wr(8'h03, {p, 3'b000});
    // ticks of an earlier run must leave the 32-tap line first
    repeat (34) @(posedge clk);
    ext_pixel_tick <= 1'b1;
    @(posedge clk);
    ext_pixel_tick <= 1'b0;
    for (n = 1; n < 40; n++) begin
      @(negedge clk);
      if (sample_tick === 1'b1) break;
    end
    lim(n, 40);
    chk(12'(n), 12'(p) + 12'h001);
  endtask
  task automatic hs_delay(input logic [4:0] p, input logic pol, output int d);
    wr(8'h03, {p, 3'b000});
    wr(8'h12, {3'b000, pol, 4'h0});
    hs_pol <= pol;
    hs_run <= 1'b1;
    repeat (40) @(posedge clk);
    @(negedge clk);
    for (d = 0; d < 64 && hsync_pin === pol; d++) @(negedge clk);
    for (d = 0; d < 64 && hsync_pin !== pol; d++) @(negedge clk);
    lim(d, 64);
    for (d = 0; d < 64 && phase_aligned_hsync_out !== 1'b1; d++) @(negedge clk);
    lim(d, 64);
    @(posedge clk);
    hs_run <= 1'b0;
  endtask
  task automatic t_phase_aligned_hsync_out;
    int d0;
    int d3;
    hs_delay(5'h00, 1'b1, d0);
    hs_delay(5'h03, 1'b0, d3);
    chk(12'(d3 - d0), 12'h003);
  endtask
  task automatic t_hold;
    logic [4:0] e;
    for (int i = 0; i < 6; i++) begin
      e = tbl[i];
      wr(8'h18, {2'b00, e[4], 5'h00});
      coast_pin <= e[3];
      coast_internal_en <= e[2];
      vsync_pin <= e[1];
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(hold_active, e[0]);
    end
  endtask
  task automatic t_lock;
    int n;
    @(posedge clk);
    ext_clk_sel <= 1'b0;
    coast_internal_en <= 1'b0;
    coast_pin <= 1'b0;
    wr(8'h04, 8'h60);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h40);
    wr(8'h12, 8'h10);
    hs_pol <= 1'b1;
    hs_run <= 1'b1;
    for (n = 0; n < 20000 && pll_locked !== 1'b1; n++) @(negedge clk);
    lim(n, 20000);
    // a first lock may be a passing match; let the loop settle on the ratio
    repeat (640) @(posedge clk);
    @(negedge clk);
    chk(pll_locked, 1'b1);
    @(posedge clk);
    coast_pin <= 1'b1;
    repeat (8) @(posedge clk);
    hs_run <= 1'b0;
    repeat (200) @(posedge clk);
    // sync comes back mid-line while still holding
    hs_run <= 1'b1;
    repeat (100) @(posedge clk);
    n = 0;
    repeat (64) begin
      @(negedge clk);
      n += int'(pixel_tick);
    end
    // four ticks per 32-clock line must survive the missing sync
    chk(12'(n), 12'h008);
    chk(pll_locked, 1'b1);
    @(posedge clk);
    coast_pin <= 1'b0;
    repeat (200) @(posedge clk);
    @(negedge clk);
    chk(pll_locked, 1'b1);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_band();
    t_phase(5'h00);
    t_phase(5'h01);
    t_phase(5'h1f);
    t_phase_aligned_hsync_out();
    t_hold();
    t_lock();
    wrap_up();
  end
endmodule
